// ### logic/nv_ctl_pkg.sv
// Notes on behaviour
// - array writes inside the protected range are dropped, contents unchanged
// - protect 000 none, 001 180h-1FFh, 010 100h-1FFh, 011 whole array
// - protect 100 000h-03Fh, 101 000h-07Fh, 110 000h-0FFh, 111 whole array
// - trim settings live in non-volatile storage and survive total power loss
// - pin capacitor = 16*not b5 + 8,4,2,1,0.5 weights + 9 pF
// - series load 4.5pF to 20.25pF in 0.25pF steps, code 0 mid-scale
// - count trim changes counts per second, averaging out the ppm error
// - count trim bit 2 is sign: 0 positive, 1 negative; zero magnitude no change
// - count trim bit 1 gives 10ppm, bit 0 gives 20ppm
// - bus-off bit set ignores the serial bus while on battery
// - switchover bit 0 standard, 1 legacy (default)
// - reset level codes 000..100 map 4.64, 4.38, 3.09, 2.92, 2.63 V
// - reset level writes are stored regardless of array protection
// - supply below chosen level holds reset and silences the serial bus
// - register-write latch clears when a control register write completes
package nv_ctl_pkg;
  // serial device selects and register addresses
  localparam logic [6:0]  CCR_DEV_ID   = 7'h6f;
  localparam logic [15:0] ADDR_SR      = 16'h003f;
  localparam logic [15:0] ADDR_BL      = 16'h0010;
  localparam logic [15:0] ADDR_ATR     = 16'h0012;
  localparam logic [15:0] ADDR_DTR     = 16'h0013;
  localparam logic [15:0] ADDR_PWR     = 16'h0014;
  // status register fields and the enable sequence values
  localparam int          SR_BAT_BIT   = 7;
  localparam int          SR_REGISTER_WRITE_LATCH_BIT  = 2;
  localparam int          SR_WEL_BIT   = 1;
  localparam logic [7:0]  SR_CLR       = 8'h00;
  localparam logic [7:0]  SR_SET_WEL   = 8'h02;
  localparam logic [7:0]  SR_SET_REGISTER_WRITE_LATCH  = 8'h06;
  // field positions inside control bytes
  localparam int          BL_PROT_LSB  = 5;
  localparam int          BL_WD_LSB    = 3;
  localparam int          PWR_BUS_OFF_ON_BATTERY_BIT = 7;
  localparam int          PWR_BSW_BIT  = 6;
  // reset values
  localparam logic [2:0]  PROT_RST     = 3'h0;
  localparam logic [1:0]  WD_RST       = 2'h3;
  localparam logic [5:0]  ATR_RST      = 6'h00;
  localparam logic [2:0]  DTR_RST      = 3'h0;
  localparam logic        BUS_OFF_ON_BATTERY_RST     = 1'b0;
  localparam logic        BSW_RST      = 1'b1;
  // protected array bounds, 9-bit array address
  localparam int          ARRAY_AW     = 9;
  localparam logic [8:0]  PROT_UQ_LO   = 9'h180;
  localparam logic [8:0]  PROT_UH_LO   = 9'h100;
  localparam logic [8:0]  PROT_4P_HI   = 9'h03f;
  localparam logic [8:0]  PROT_8P_HI   = 9'h07f;
  localparam logic [8:0]  PROT_16P_HI  = 9'h0ff;
  // capacitor weights in half-pF units (equal to series load in quarter-pF)
  localparam logic [6:0]  CAP_W_B5     = 7'h20;
  localparam logic [6:0]  CAP_FIXED    = 7'h12;
  // reset thresholds in mV
  localparam logic [12:0] VRST_000     = 13'h1220;
  localparam logic [12:0] VRST_001     = 13'h111c;
  localparam logic [12:0] VRST_010     = 13'h0c12;
  localparam logic [12:0] VRST_011     = 13'h0b68;
  localparam logic [12:0] VRST_100     = 13'h0a46;
  // count trim: oscillator counts per second, ppm denominator, one 10ppm step
  localparam logic [16:0] OSC_PER_SEC  = 17'h08000;
  localparam logic [20:0] PPM_DEN      = 21'h0f4240;
  localparam logic [20:0] TRIM_UNIT    = 21'h050000;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_RX    = 5'h02,
    ST_ACK   = 5'h04,
    ST_TX    = 5'h08,
    ST_TXACK = 5'h10
  } bus_st_e;

  typedef struct packed {
    logic [2:0] protect_sel;
    logic [1:0] wd_sel;
    logic [5:0] cap_trim;
    logic [2:0] count_trim;
    logic       bus_off_on_battery;
    logic       switchover_mode_sel;
    logic [2:0] reset_level;
  } nv_regs_s;
endpackage

// ### logic/nv_protect_trim_power_regs.sv
`timescale 1ns/100ps
module nv_protect_trim_power_regs
  import nv_ctl_pkg::*;
#(
  parameter logic [6:0] ARRAY_DEV_ID = 7'h50,  // arbitrary value
  parameter logic [2:0] VTS_DEFAULT  = 3'h0
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        on_battery,
  input  wire logic [12:0] supply_mv,
  input  wire logic        osc_tick,
  input  wire logic [7:0]  array_rd_data,
  output logic [8:0]       array_addr,
  output logic             array_wr,
  output logic [8:0]       array_wr_addr,
  output logic [7:0]       array_wr_data,
  output logic [2:0]       protect_sel,
  output logic [6:0]       cap_half_pf,
  output logic             sec_tick,
  output logic             switchover_mode_sel,
  output logic [12:0]      reset_threshold_mv,
  output logic             supply_reset
);
  if (VTS_DEFAULT > 3'h4) begin : g_chk
    $error("VTS_DEFAULT must be a defined reset level code");
  end

  // protected-range decode of the array address
  function automatic logic prot_hit(input logic [2:0] sel, input logic [8:0] a);
    logic hit;
    hit = 1'b0;
    case (sel)
      3'h1: hit = (a >= PROT_UQ_LO);
      3'h2: hit = (a >= PROT_UH_LO);
      3'h3: hit = 1'b1;
      3'h4: hit = (a <= PROT_4P_HI);
      3'h5: hit = (a <= PROT_8P_HI);
      3'h6: hit = (a <= PROT_16P_HI);
      3'h7: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // undefined codes fall back to the highest level, the safe side for a supervisor
  function automatic logic [12:0] level_mv(input logic [2:0] code);
    logic [12:0] mv;
    case (code)
      3'h1: mv = VRST_001;
      3'h2: mv = VRST_010;
      3'h3: mv = VRST_011;
      3'h4: mv = VRST_100;
      default: mv = VRST_000;
    endcase
    return mv;
  endfunction

  logic        scl_q_ff, sda_q_ff;
  bus_st_e     st_ff, nxt_st;
  logic [3:0]  bitcnt_ff, nxt_bitcnt;
  logic [7:0]  shift_ff, nxt_shift;
  logic [1:0]  byte_idx_ff, nxt_byte_idx;
  logic        is_ccr_ff, nxt_is_ccr;
  logic        is_read_ff, nxt_is_read;
  logic [15:0] addr_ff, nxt_addr;
  logic        wel_ff, nxt_wel;
  logic        register_write_latch_ff, nxt_register_write_latch;
  logic        ctl_wr_ff, nxt_ctl_wr;
  logic        sda_oe_ff, nxt_sda_oe;
  logic        array_wr_ff, nxt_array_wr;
  logic [8:0]  array_wr_addr_ff, nxt_array_wr_addr;
  logic [7:0]  array_wr_data_ff, nxt_array_wr_data;
  nv_regs_s    regs_ff, nxt_regs;
  logic        sda_o_ff;
  logic        supply_reset_ff;
  logic        scl_rise, scl_fall, start_c, stop_c, bus_ok;
  logic [7:0]  ccr_rd, tx_byte;

  // bus line events, inputs taken as already synchronous
  assign scl_rise = scl_i & ~scl_q_ff;
  assign scl_fall = ~scl_i & scl_q_ff;
  assign start_c  = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop_c   = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  assign bus_ok   = ~(regs_ff.bus_off_on_battery & on_battery) & ~supply_reset_ff;

  // readback of the control space; unassigned bits stay zero
  always_comb begin
    ccr_rd = 8'h00;
    case (addr_ff)
      ADDR_SR: begin
        ccr_rd[SR_BAT_BIT]  = on_battery;
        ccr_rd[SR_REGISTER_WRITE_LATCH_BIT] = register_write_latch_ff;
        ccr_rd[SR_WEL_BIT]  = wel_ff;
      end
      ADDR_BL: begin
        ccr_rd[BL_PROT_LSB +: 3] = regs_ff.protect_sel;
        ccr_rd[BL_WD_LSB +: 2]   = regs_ff.wd_sel;
      end
      ADDR_ATR: ccr_rd[5:0] = regs_ff.cap_trim;
      ADDR_DTR: ccr_rd[2:0] = regs_ff.count_trim;
      ADDR_PWR: begin
        ccr_rd[PWR_BUS_OFF_ON_BATTERY_BIT] = regs_ff.bus_off_on_battery;
        ccr_rd[PWR_BSW_BIT]  = regs_ff.switchover_mode_sel;
        ccr_rd[2:0]          = regs_ff.reset_level;
      end
      default: ccr_rd = 8'h00;
    endcase
    tx_byte = is_ccr_ff ? ccr_rd : array_rd_data;
  end

  // serial slave, byte handling and register writes
  always_comb begin
    nxt_st            = st_ff;
    nxt_bitcnt        = bitcnt_ff;
    nxt_shift         = shift_ff;
    nxt_byte_idx      = byte_idx_ff;
    nxt_is_ccr        = is_ccr_ff;
    nxt_is_read       = is_read_ff;
    nxt_addr          = addr_ff;
    nxt_wel           = wel_ff;
    nxt_register_write_latch          = register_write_latch_ff;
    nxt_ctl_wr        = ctl_wr_ff;
    nxt_sda_oe        = sda_oe_ff;
    nxt_array_wr      = 1'b0;
    nxt_array_wr_addr = array_wr_addr_ff;
    nxt_array_wr_data = array_wr_data_ff;
    nxt_regs          = regs_ff;
    if (stop_c || !bus_ok) begin
      // a write only counts as complete on a stop, never on a repeated start
      if (stop_c && ctl_wr_ff) begin
        nxt_register_write_latch = 1'b0;
      end
      nxt_ctl_wr = 1'b0;
      nxt_st     = ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (start_c) begin
      nxt_st       = ST_RX;
      nxt_bitcnt   = 4'h0;
      nxt_byte_idx = 2'h0;
      nxt_sda_oe   = 1'b0;
    end else begin
      case (st_ff)
        ST_RX: begin
          if (scl_rise) begin
            nxt_shift  = {shift_ff[6:0], sda_i};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end else if (scl_fall && bitcnt_ff == 4'h8) begin
            nxt_st     = ST_ACK;
            nxt_sda_oe = 1'b1;
            if (byte_idx_ff != 2'h3) begin
              nxt_byte_idx = byte_idx_ff + 2'h1;
            end
            case (byte_idx_ff)
              2'h0: begin
                nxt_is_ccr  = (shift_ff[7:1] == CCR_DEV_ID);
                nxt_is_read = shift_ff[0];
                if (shift_ff[7:1] != CCR_DEV_ID && shift_ff[7:1] != ARRAY_DEV_ID) begin
                  nxt_st     = ST_IDLE;
                  nxt_sda_oe = 1'b0;
                end
              end
              2'h1: nxt_addr[15:8] = shift_ff;
              2'h2: nxt_addr[7:0] = shift_ff;
              default: begin
                nxt_addr = addr_ff + 16'h0001;
                if (!is_ccr_ff) begin
                  nxt_array_wr      = ~prot_hit(regs_ff.protect_sel, addr_ff[8:0]);
                  nxt_array_wr_addr = addr_ff[8:0];
                  nxt_array_wr_data = shift_ff;
                end else if (addr_ff == ADDR_SR) begin
                  // only the exact sequence values move the latches
                  if (shift_ff == SR_CLR) begin
                    nxt_wel  = 1'b0;
                    nxt_register_write_latch = 1'b0;
                  end else if (shift_ff == SR_SET_WEL) begin
                    nxt_wel  = 1'b1;
                    nxt_register_write_latch = 1'b0;
                  end else if (shift_ff == SR_SET_REGISTER_WRITE_LATCH && wel_ff) begin
                    nxt_register_write_latch = 1'b1;
                  end
                end else if (register_write_latch_ff) begin
                  // writes land in named fields only, so spare bits are dropped
                  case (addr_ff)
                    ADDR_BL: begin
                      nxt_regs.protect_sel = shift_ff[BL_PROT_LSB +: 3];
                      nxt_regs.wd_sel      = shift_ff[BL_WD_LSB +: 2];
                      nxt_ctl_wr           = 1'b1;
                    end
                    ADDR_ATR: begin
                      nxt_regs.cap_trim = shift_ff[5:0];
                      nxt_ctl_wr        = 1'b1;
                    end
                    ADDR_DTR: begin
                      nxt_regs.count_trim = shift_ff[2:0];
                      nxt_ctl_wr          = 1'b1;
                    end
                    ADDR_PWR: begin
                      nxt_regs.bus_off_on_battery  = shift_ff[PWR_BUS_OFF_ON_BATTERY_BIT];
                      nxt_regs.switchover_mode_sel = shift_ff[PWR_BSW_BIT];
                      nxt_regs.reset_level         = shift_ff[2:0];
                      nxt_ctl_wr                   = 1'b1;
                    end
                    default: nxt_ctl_wr = ctl_wr_ff;
                  endcase
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (is_read_ff) begin
              nxt_st     = ST_TX;
              nxt_sda_oe = ~tx_byte[7];
              nxt_shift  = {tx_byte[6:0], 1'b0};
              nxt_bitcnt = 4'h1;
              nxt_addr   = addr_ff + 16'h0001;
            end else begin
              nxt_st     = ST_RX;
              nxt_sda_oe = 1'b0;
              nxt_bitcnt = 4'h0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt_ff == 4'h8) begin
              nxt_st     = ST_TXACK;
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_sda_oe = ~shift_ff[7];
              nxt_shift  = {shift_ff[6:0], 1'b0};
              nxt_bitcnt = bitcnt_ff + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            nxt_st = sda_i ? ST_IDLE : ST_ACK;
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  // regs_ff stands for the non-volatile cells: only sys_rst (factory load) resets
  // them, a supply reset leaves them alone while the volatile latches drop
  always_ff @(posedge clk) begin
    scl_q_ff <= scl_i;
    sda_q_ff <= sda_i;
    sda_o_ff <= 1'b0;
    if (sys_rst) begin
      st_ff            <= ST_IDLE;
      bitcnt_ff        <= 4'h0;
      shift_ff         <= 8'h00;
      byte_idx_ff      <= 2'h0;
      is_ccr_ff        <= 1'b0;
      is_read_ff       <= 1'b0;
      addr_ff          <= 16'h0000;
      wel_ff           <= 1'b0;
      register_write_latch_ff          <= 1'b0;
      ctl_wr_ff        <= 1'b0;
      sda_oe_ff        <= 1'b0;
      array_wr_ff      <= 1'b0;
      array_wr_addr_ff <= 9'h000;
      array_wr_data_ff <= 8'h00;
      regs_ff          <= '{PROT_RST, WD_RST, ATR_RST, DTR_RST, BUS_OFF_ON_BATTERY_RST, BSW_RST,
                            VTS_DEFAULT};
    end else begin
      st_ff            <= nxt_st;
      bitcnt_ff        <= nxt_bitcnt;
      shift_ff         <= nxt_shift;
      byte_idx_ff      <= nxt_byte_idx;
      is_ccr_ff        <= nxt_is_ccr;
      is_read_ff       <= nxt_is_read;
      addr_ff          <= nxt_addr;
      wel_ff           <= nxt_wel & ~supply_reset_ff;
      register_write_latch_ff          <= nxt_register_write_latch & ~supply_reset_ff;
      ctl_wr_ff        <= nxt_ctl_wr;
      sda_oe_ff        <= nxt_sda_oe;
      array_wr_ff      <= nxt_array_wr;
      array_wr_addr_ff <= nxt_array_wr_addr;
      array_wr_data_ff <= nxt_array_wr_data;
      regs_ff          <= nxt_regs;
    end
  end

  // trim outputs and supply supervisor
  logic [6:0]  cap_ff, nxt_cap;
  logic [12:0] thr_ff;
  always_comb begin
    nxt_cap = (regs_ff.cap_trim[5] ? 7'h00 : CAP_W_B5)
            + {2'b00, regs_ff.cap_trim[4:0]} + CAP_FIXED;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap_ff          <= 7'h00;
      thr_ff          <= VRST_000;
      supply_reset_ff <= 1'b0;
    end else begin
      cap_ff          <= nxt_cap;
      thr_ff          <= level_mv(regs_ff.reset_level);
      supply_reset_ff <= (supply_mv < thr_ff);
    end
  end

  // seconds from oscillator counts; the fraction is carried so the mean rate is exact
  logic [16:0] cnt_ff, nxt_cnt, per_ff, nxt_per;
  logic [20:0] acc_ff, nxt_acc, acc_sum;
  logic        sec_ff, nxt_sec;
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_per = per_ff;
    nxt_acc = acc_ff;
    nxt_sec = 1'b0;
    acc_sum = acc_ff + (regs_ff.count_trim[1] ? TRIM_UNIT : 21'h000000)
            + (regs_ff.count_trim[0] ? {TRIM_UNIT[19:0], 1'b0} : 21'h000000);
    if (osc_tick) begin
      if (cnt_ff >= per_ff - 17'h00001) begin
        nxt_cnt = 17'h00000;
        nxt_sec = 1'b1;
        nxt_per = OSC_PER_SEC;
        nxt_acc = acc_sum;
        if (acc_sum >= PPM_DEN) begin
          nxt_acc = acc_sum - PPM_DEN;
          // a faster clock needs fewer counts per second
          nxt_per = regs_ff.count_trim[2] ? OSC_PER_SEC + 17'h00001
                                          : OSC_PER_SEC - 17'h00001;
        end
      end else begin
        nxt_cnt = cnt_ff + 17'h00001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff <= 17'h00000;
      per_ff <= OSC_PER_SEC;
      acc_ff <= 21'h000000;
      sec_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      per_ff <= nxt_per;
      acc_ff <= nxt_acc;
      sec_ff <= nxt_sec;
    end
  end

  assign sda_o               = sda_o_ff;
  assign sda_oe              = sda_oe_ff;
  assign array_addr          = addr_ff[8:0];
  assign array_wr            = array_wr_ff;
  assign array_wr_addr       = array_wr_addr_ff;
  assign array_wr_data       = array_wr_data_ff;
  assign protect_sel         = regs_ff.protect_sel;
  assign cap_half_pf         = cap_ff;
  assign sec_tick            = sec_ff;
  assign switchover_mode_sel = regs_ff.switchover_mode_sel;
  assign reset_threshold_mv  = thr_ff;
  assign supply_reset        = supply_reset_ff;
endmodule

// ### verif/i2c_host_model.sv
`timescale 1ns/100ps
module i2c_host_model (
  input  wire logic clk,
  input  wire logic dev_oe,
  output logic      scl,
  output logic      sda
);
  logic drv_low = 1'b0;

  // pull-up on the data line: high unless a party pulls it low
  assign sda = !(drv_low || dev_oe);

  initial scl = 1'b1;

  // one phase of three clocks, above the two-clock minimum of the slave
  task automatic step(input logic l, input logic c);
    @(negedge clk);
    drv_low = l;
    scl = c;
    repeat (2) @(negedge clk);
  endtask

  // scl falls before data moves, so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    step(drv_low, 1'b0);
    step(!b, 1'b0);
    step(!b, 1'b1);
    r = sda;
  endtask

  task automatic start();
    step(drv_low, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
  endtask

  task automatic stop();
    step(drv_low, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(nack, r);
  endtask
endmodule

// ### verif/nv_regs_monitor.sv
`timescale 1ns/100ps
module nv_regs_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        osc_tick,
  input wire logic        array_wr,
  input wire logic [8:0]  array_wr_addr,
  input wire logic [2:0]  protect_sel,
  input wire logic [6:0]  cap_half_pf,
  input wire logic        sec_tick,
  input wire logic [12:0] supply_mv,
  input wire logic [12:0] reset_threshold_mv,
  input wire logic        supply_reset
);
  logic [16:0] tick_cnt_ff;
  logic [16:0] nxt_tick_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // protected range of each select code
  function automatic logic hit(input logic [2:0] p, input logic [8:0] a);
    return (p == 3'h3) || (p == 3'h7) || (p == 3'h1 && a >= 9'h180) ||
      (p == 3'h2 && a >= 9'h100) || (p == 3'h4 && a <= 9'h03f) ||
      (p == 3'h5 && a <= 9'h07f) || (p == 3'h6 && a <= 9'h0ff);
  endfunction

  // oscillator counts since the last trimmed second; a tick in the
  // second-pulse cycle already belongs to the next second
  always_comb begin
    nxt_tick_cnt = sec_tick ? 17'(osc_tick) : tick_cnt_ff + 17'(osc_tick);
  end

  always_ff @(posedge clk) begin
    tick_cnt_ff <= sys_rst ? 17'h00000 : nxt_tick_cnt;
  end

  a_oe_low_only:
    assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");
  a_oe_scl_low:
    assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed while clock high");
  a_wr_outside:
    assert property (array_wr |-> !hit(protect_sel, array_wr_addr))
    else $error("array write inside protected range");
  a_wr_with_ack:
    assert property (array_wr |-> $rose(sda_oe))
    else $error("array write not aligned with data ack");
  a_level_legal:
    assert property (reset_threshold_mv inside {13'h1220, 13'h111c, 13'h0c12, 13'h0b68,
                                                13'h0a46})
    else $error("reset threshold off the table");
  a_cap_span:
    assert property (!$past(sys_rst) |-> cap_half_pf inside {[7'h12:7'h51]})
    else $error("capacitor setting out of span");
  a_reset_follows:
    assert property (supply_reset == $past(supply_mv < reset_threshold_mv))
    else $error("supply reset does not follow threshold");
  a_quiet_reset:
    assert property (supply_reset && $past(supply_reset) |-> !sda_oe)
    else $error("data line driven during supply reset");
  a_sec_count:
    assert property (sec_tick |-> tick_cnt_ff inside {[17'h07fff:17'h08001]})
    else $error("second length outside trim span");
  a_sec_pulse:
    assert property (sec_tick |=> !sec_tick)
    else $error("second pulse longer than one cycle");
endmodule

bind nv_protect_trim_power_regs nv_regs_monitor nv_regs_monitor_i (
  .clk, .sys_rst, .scl_i, .sda_o, .sda_oe, .osc_tick, .array_wr, .array_wr_addr,
  .protect_sel, .cap_half_pf, .sec_tick, .supply_mv, .reset_threshold_mv, .supply_reset);

// ### verif/nv_protect_trim_power_regs_tb.sv
`timescale 1ns/100ps
module nv_protect_trim_power_regs_tb
  import nv_ctl_pkg::*;
;
  localparam logic [6:0] ARR_ID = 7'h50;  // arbitrary value
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        on_battery = 1'b0;
  logic        osc_tick = 1'b0;
  logic [12:0] supply_mv = 13'h1388;
  logic [7:0]  array_rd_data = 8'h00;
  logic        scl, sda, sda_o, sda_oe, array_wr, sec_tick, switchover_mode_sel, supply_reset;
  logic [8:0]  array_wr_addr;
  logic [7:0]  array_wr_data, rd_got;
  logic [2:0]  protect_sel;
  logic [6:0]  cap_half_pf;
  logic [12:0] reset_threshold_mv;
  int          seed = 32'hadd9;
  int          fail_count = 0;
  int          checks = 0;
  logic [7:0]  rq[$];
  logic [16:0] wq[$];
  event        rd_ev;
  logic [12:0] thr[5] = '{13'h1220, 13'h111c, 13'h0c12, 13'h0b68, 13'h0a46};
  logic [8:0]  adr[10] = '{9'h000, 9'h03f, 9'h040, 9'h07f, 9'h080, 9'h0ff, 9'h100, 9'h17f,
                          9'h180, 9'h1ff};

  always #4 clk = ~clk;

  nv_protect_trim_power_regs #(.ARRAY_DEV_ID(ARR_ID)) nv_protect_trim_power_regs_i (
    .clk, .sys_rst, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe, .on_battery, .supply_mv,
    .osc_tick, .array_rd_data, .array_addr(), .array_wr, .array_wr_addr, .array_wr_data,
    .protect_sel, .cap_half_pf, .sec_tick, .switchover_mode_sel, .reset_threshold_mv,
    .supply_reset);

  i2c_host_model i2c_host_model_i (.clk, .dev_oe(sda_oe), .scl, .sda);

  function automatic logic hit(input logic [2:0] p, input logic [8:0] a);
    return (p == 3'h3) || (p == 3'h7) || (p == 3'h1 && a >= 9'h180) ||
      (p == 3'h2 && a >= 9'h100) || (p == 3'h4 && a <= 9'h03f) ||
      (p == 3'h5 && a <= 9'h07f) || (p == 3'h6 && a <= 9'h0ff);
  endfunction

  task automatic summarize();
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic report(input logic bad, input logic [16:0] g, input logic [16:0] e);
    checks++;
    if (bad) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
    report(g !== e, 17'(g), 17'(e));
  endtask

  task automatic cmp_wr(input logic [16:0] g, input logic [16:0] e);
    report(g !== e, g, e);
  endtask

  task automatic cmp_out(input logic [12:0] g, input logic [12:0] e);
    report(g !== e, 17'(g), 17'(e));
  endtask

  // one write transfer; a refused device select ends it at once
  task automatic xfer(input logic [6:0] dev, input logic [15:0] a, input logic [7:0] d,
                      input logic ea);
    logic k;
    i2c_host_model_i.start();
    i2c_host_model_i.wbyte({dev, 1'b0}, k);
    cmp_out(13'(k), 13'(ea));
    if (k) begin
      i2c_host_model_i.wbyte(a[15:8], k);
      i2c_host_model_i.wbyte(a[7:0], k);
      i2c_host_model_i.wbyte(d, k);
    end
    i2c_host_model_i.stop();
  endtask

  // address set by a write, then repeated start and a single read byte
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    logic k;
    rq.push_back(e);
    i2c_host_model_i.start();
    i2c_host_model_i.wbyte({CCR_DEV_ID, 1'b0}, k);
    i2c_host_model_i.wbyte(a[15:8], k);
    i2c_host_model_i.wbyte(a[7:0], k);
    i2c_host_model_i.start();
    i2c_host_model_i.wbyte({CCR_DEV_ID, 1'b1}, k);
    i2c_host_model_i.rbyte(1'b1, rd_got);
    i2c_host_model_i.stop();
    -> rd_ev;
  endtask

  // control write behind the two-step latch sequence
  task automatic wcr(input logic [15:0] a, input logic [7:0] d);
    xfer(CCR_DEV_ID, ADDR_SR, 8'h02, 1'b1);
    xfer(CCR_DEV_ID, ADDR_SR, 8'h06, 1'b1);
    xfer(CCR_DEV_ID, a, d, 1'b1);
  endtask

  // result watchers take the oldest note for each read and array write
  always @(rd_ev) cmp_rd(rd_got, rq.pop_front());
  always @(negedge clk)
    if (array_wr === 1'b1)
      cmp_wr({array_wr_addr, array_wr_data}, wq.size() != 0 ? wq.pop_front() : 'x);

  // free-running random oscillator ticks and array read data
  always @(negedge clk) begin
    osc_tick <= ($random(seed) % 4) != 0;
    array_rd_data <= 8'($random(seed));
  end

  initial begin
    repeat (95000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial begin
    logic [7:0] c;
    logic [7:0] d;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    cmp_out(13'(protect_sel), 13'h0);
    cmp_out(13'(switchover_mode_sel), 13'h1);
    cmp_out(reset_threshold_mv, 13'h1220);
    cmp_out(13'(cap_half_pf), 13'h32);
    rd(ADDR_BL, 8'h18);
    rd(ADDR_PWR, 8'h40);
    rd(ADDR_DTR, 8'h00);
    xfer(CCR_DEV_ID, ADDR_ATR, 8'h3f, 1'b1);
    rd(ADDR_ATR, 8'h00);
    // both ends of the capacitor span, then a random code
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 8'h20 : (i == 1) ? 8'h1f : 8'($random(seed)) & 8'h3f;
      wcr(ADDR_ATR, c | 8'hc0);
      rd(ADDR_ATR, c);
      cmp_out(13'(cap_half_pf), 13'(c[5] ? 7'h12 : 7'h32) + 13'(c[4:0]));
    end
    xfer(CCR_DEV_ID, ADDR_ATR, 8'h00, 1'b1);
    rd(ADDR_ATR, c);
    wcr(ADDR_DTR, 8'hff);
    rd(ADDR_DTR, 8'h07);
    // every protect code against the edges of each range
    for (int p = 0; p < 8; p++) begin
      wcr(ADDR_BL, {3'(p), 5'h1f});
      rd(ADDR_BL, {3'(p), 5'h18});
      cmp_out(13'(protect_sel), 13'(p));
      foreach (adr[j]) begin
        d = 8'($random(seed));
        if (!hit(3'(p), adr[j]))
          wq.push_back({adr[j], d});
        xfer(ARR_ID, 16'(adr[j]), d, 1'b1);
      end
    end
    // full protection stays on while the reset levels are stepped
    for (int v = 0; v < 5; v++) begin
      wcr(ADDR_PWR, {1'b0, 1'(v), 3'h0, 3'(v)});
      cmp_out(reset_threshold_mv, thr[v]);
      cmp_out(13'(switchover_mode_sel), 13'(v & 1));
    end
    wcr(ADDR_PWR, 8'h02);
    supply_mv = 13'h0bb8;
    repeat (4) @(negedge clk);
    cmp_out(13'(supply_reset), 13'h1);
    xfer(CCR_DEV_ID, ADDR_SR, 8'h02, 1'b0);
    supply_mv = 13'h1388;
    repeat (4) @(negedge clk);
    rd(ADDR_PWR, 8'h02);
    wcr(ADDR_PWR, 8'h82);
    on_battery = 1'b1;
    xfer(CCR_DEV_ID, ADDR_SR, 8'h02, 1'b0);
    on_battery = 1'b0;
    wcr(ADDR_PWR, 8'h02);
    on_battery = 1'b1;
    rd(ADDR_SR, 8'h82);
    rd(ADDR_PWR, 8'h02);
    on_battery = 1'b0;
    cmp_out(13'(wq.size()), 13'h0);
    summarize();
  end
endmodule
